// *** verilog/acr_defs.vh ***
// constants for the accumulator config, range image and alert status registers
//
// Notes on behaviour
// - bus range field: 00 unipolar 0..+32V, 01 bipolar 32V, 10 bipolar 16V, 11 reserved
// - bus range fields in image: ch1 bits 7-6, ch2 5-4, ch3 3-2, ch4 1-0
// - ch4 sense range bits 9-8: 00 unipolar 100mV, 01 bipolar 100mV, 10 bipolar 50mV
// - accumulator source: 00 power product, 01 sense voltage, 10 bus voltage
// - accumulator source fields: ch1 bits 7-6, ch2 5-4, ch3 3-2, ch4 1-0
// - after reset all accumulator source bits are zero, power accumulation everywhere
// - source code 11 is reserved and reads back as zero
// - a status flag clears only after a read and then a completed conversion
// - a flag whose condition still holds at that conversion stays set
// - status value updates directly, no refresh command needed
// - current, voltage and power alerts flag only when their enables are set
// - overcurrent flags ch1..ch4 in status bits 23..20, one means tripped
// - undercurrent flags ch1..ch4 in status bits 19..16
// - overvoltage flags in bits 15..12, undervoltage flags in bits 11..8
// - overpower bits 7..4, accumulator full bit 3, count full bit 2, bits 1-0 zero
// - accumulator full flag sets on any channel accumulator overflow or limit
// - count full flag sets on sample counter overflow or limit
// - range image holds the settings in force before the latest refresh, or the data of a host write made since
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define ACR_ADDR_RANGE_IMAGE   8'h24
`define ACR_ADDR_ACCUM_SOURCE  8'h25
`define ACR_ADDR_ALERT_FLAGS   8'h26

// ***************************************************************
// reset values and widths
// ***************************************************************
`define ACR_RANGE_IMAGE_RST    10'h000
`define ACR_ACCUM_SOURCE_RST   8'h00
`define ACR_ALERT_FLAGS_RST    22'h000000
`define ACR_RDATA_ZERO         24'h000000

// ***************************************************************
// field positions
// ***************************************************************
`define ACR_SENSE4_HI          9
`define ACR_SENSE4_LO          8
`define ACR_OC_LO              20
`define ACR_UC_LO              16
`define ACR_OV_LO              12
`define ACR_UV_LO              8
`define ACR_OP_LO              4
`define ACR_ACC_FULL_BIT       3
`define ACR_CNT_FULL_BIT       2
`define ACR_FLAGS_LO           2

// ***************************************************************
// field codes
// ***************************************************************
`define ACR_RANGE_UNIPOLAR     2'h0
`define ACR_RANGE_BIPOLAR_FULL 2'h1
`define ACR_RANGE_BIPOLAR_HALF 2'h2
`define ACR_RANGE_RESERVED     2'h3
`define ACR_SRC_POWER          2'h0
`define ACR_SRC_SENSE          2'h1
`define ACR_SRC_BUS            2'h2
`define ACR_SRC_RESERVED       2'h3

`endif

// *** verilog/acr_regs.v ***
// range image, accumulator source and alert status register logic
`timescale 1ns/1ps
`include "acr_defs.vh"

module acr_regs #(
   parameter NUM_CH = 4
) (
   input  wire                clk,
   input  wire                rst_n,
   input  wire [7:0]          reg_addr,
   input  wire                reg_wr,
   input  wire [23:0]         reg_wdata,
   input  wire                reg_rd,
   input  wire                refresh,
   input  wire [9:0]          range_active,
   input  wire                conv_done,
   input  wire [NUM_CH-1:0]   oc_trip,
   input  wire [NUM_CH-1:0]   uc_trip,
   input  wire [NUM_CH-1:0]   ov_trip,
   input  wire [NUM_CH-1:0]   uv_trip,
   input  wire [NUM_CH-1:0]   op_trip,
   input  wire                accum_full_trip,
   input  wire                count_full_trip,
   input  wire [23:4]         alert_enable,
   output reg  [23:0]         reg_rdata,
   output reg                 reg_rvalid,
   output reg  [9:0]          range_select_latched_image,
   output reg  [7:0]          accumulator_source_select,
   output reg  [23:0]         limit_alert_flags,
   output reg                 alert_any,
   output reg  [NUM_CH-1:0]   accum_src_power,
   output reg  [NUM_CH-1:0]   accum_src_sense,
   output reg  [NUM_CH-1:0]   accum_src_bus,
   output reg  [NUM_CH-1:0]   bus_range_bipolar,
   output reg  [NUM_CH-1:0]   bus_range_half,
   output reg  [NUM_CH-1:0]   bus_range_reserved,
   output reg                 sense_range_bipolar_ch4,
   output reg                 sense_range_half_ch4,
   output reg                 sense_range_reserved_ch4
);

// ***************************************************************
// decode and write data preparation
// ***************************************************************
wire                sel_image;
wire                sel_source;
wire                sel_flags;
wire [7:0]          wr_source_clean;
wire [21:0]         trip_vec;
wire [21:0]         trip_enabled;
reg                 read_pending;
reg  [21:0]         next_flags;
reg                 next_read_pending;
reg  [23:0]         next_rdata;

assign sel_image  = (reg_addr == `ACR_ADDR_RANGE_IMAGE);
assign sel_source = (reg_addr == `ACR_ADDR_ACCUM_SOURCE);
assign sel_flags  = (reg_addr == `ACR_ADDR_ALERT_FLAGS);

// reserved source code is stored as the power code at write time so it can never steer the accumulator
genvar g;
generate
   for (g = 0; g < NUM_CH; g = g + 1) begin : g_src
      wire [1:0] code_in;
      assign code_in = reg_wdata[2*g+1:2*g];
      assign wr_source_clean[2*g+1:2*g] =
         (code_in == `ACR_SRC_RESERVED) ? `ACR_SRC_POWER : code_in;
   end
endgenerate

// channel 1 is the most significant bit of every four-bit group
assign trip_vec = {oc_trip[0], oc_trip[1], oc_trip[2], oc_trip[3],
                   uc_trip[0], uc_trip[1], uc_trip[2], uc_trip[3],
                   ov_trip[0], ov_trip[1], ov_trip[2], ov_trip[3],
                   uv_trip[0], uv_trip[1], uv_trip[2], uv_trip[3],
                   op_trip[0], op_trip[1], op_trip[2], op_trip[3],
                   accum_full_trip, count_full_trip};

// fullness flags carry no enable of their own here
assign trip_enabled = trip_vec & {alert_enable[23:4], 2'b11};

// ***************************************************************
// alert flag update
// ***************************************************************
always @* begin
   next_flags        = limit_alert_flags[23:`ACR_FLAGS_LO];
   next_read_pending = read_pending;
   if (conv_done) begin
      if (read_pending) begin
         // a read was seen earlier: drop old flags, keep only live conditions
         next_flags = trip_enabled;
      end else begin
         next_flags = next_flags | trip_enabled;
      end
      next_read_pending = 1'b0;
   end
   // a read in the same cycle as conversion end waits for the following conversion
   if (reg_rd && sel_flags) begin
      next_read_pending = 1'b1;
   end
end

// ***************************************************************
// read data mux
// ***************************************************************
always @* begin
   next_rdata = `ACR_RDATA_ZERO;
   if (sel_image) begin
      next_rdata[9:0] = range_select_latched_image;
   end else if (sel_source) begin
      next_rdata[7:0] = accumulator_source_select;
   end else if (sel_flags) begin
      next_rdata = limit_alert_flags;
   end
end

// ***************************************************************
// registers
// ***************************************************************
always @(posedge clk) begin
   if (!rst_n) begin
      range_select_latched_image <= `ACR_RANGE_IMAGE_RST;
      accumulator_source_select  <= `ACR_ACCUM_SOURCE_RST;
      limit_alert_flags          <= {`ACR_ALERT_FLAGS_RST, 2'b00};
      read_pending               <= 1'b0;
      reg_rdata                  <= `ACR_RDATA_ZERO;
      reg_rvalid                 <= 1'b0;
      alert_any                  <= 1'b0;
   end else begin
      // refresh wins over a host write landing in the same cycle
      if (refresh) begin
         range_select_latched_image <= range_active;
      end else if (reg_wr && sel_image) begin
         range_select_latched_image <= reg_wdata[9:0];
      end
      if (reg_wr && sel_source) begin
         accumulator_source_select <= wr_source_clean;
      end
      limit_alert_flags <= {next_flags, 2'b00};
      read_pending      <= next_read_pending;
      alert_any         <= |next_flags;
      reg_rvalid        <= reg_rd;
      if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end
end

// ***************************************************************
// per channel decode of source and bus range
// ***************************************************************
generate
   for (g = 0; g < NUM_CH; g = g + 1) begin : g_dec
      // channel 1 sits in the top pair, channel 4 in the bottom pair
      wire [1:0] src;
      wire [1:0] rng;
      assign src = accumulator_source_select[2*(NUM_CH-1-g)+1:2*(NUM_CH-1-g)];
      assign rng = range_select_latched_image[2*(NUM_CH-1-g)+1:2*(NUM_CH-1-g)];
      always @(posedge clk) begin
         if (!rst_n) begin
            accum_src_power[g]    <= 1'b1;
            accum_src_sense[g]    <= 1'b0;
            accum_src_bus[g]      <= 1'b0;
            bus_range_bipolar[g]  <= 1'b0;
            bus_range_half[g]     <= 1'b0;
            bus_range_reserved[g] <= 1'b0;
         end else begin
            accum_src_power[g]    <= (src == `ACR_SRC_POWER);
            accum_src_sense[g]    <= (src == `ACR_SRC_SENSE);
            accum_src_bus[g]      <= (src == `ACR_SRC_BUS);
            bus_range_bipolar[g]  <= (rng == `ACR_RANGE_BIPOLAR_FULL) ||
                                     (rng == `ACR_RANGE_BIPOLAR_HALF);
            bus_range_half[g]     <= (rng == `ACR_RANGE_BIPOLAR_HALF);
            bus_range_reserved[g] <= (rng == `ACR_RANGE_RESERVED);
         end
      end
   end
endgenerate

// ***************************************************************
// channel 4 sense range decode
// ***************************************************************
wire [1:0] sense4;
assign sense4 = range_select_latched_image[`ACR_SENSE4_HI:`ACR_SENSE4_LO];

always @(posedge clk) begin
   if (!rst_n) begin
      sense_range_bipolar_ch4  <= 1'b0;
      sense_range_half_ch4     <= 1'b0;
      sense_range_reserved_ch4 <= 1'b0;
   end else begin
      sense_range_bipolar_ch4  <= (sense4 == `ACR_RANGE_BIPOLAR_FULL) ||
                                  (sense4 == `ACR_RANGE_BIPOLAR_HALF);
      sense_range_half_ch4     <= (sense4 == `ACR_RANGE_BIPOLAR_HALF);
      sense_range_reserved_ch4 <= (sense4 == `ACR_RANGE_RESERVED);
   end
end

endmodule // acr_regs

// *** test/acr_host_model.sv ***
// host model that issues register reads and writes on the strobe port
`timescale 1ns/1ps
module acr_host_model (
   input  wire logic        clk,
   input  wire logic        reg_rvalid,
   input  wire logic [23:0] reg_rdata,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [23:0] reg_wdata,
   output logic             reg_rd
);
   initial begin
      reg_addr = 8'hFF;
      reg_wr = 1'b0;
      reg_wdata = 24'h000000;
      reg_rd = 1'b0;
   end
   // released address is inverted after both tasks, write data after wr only, so stale values are never trusted
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk) #1;
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge clk) #1;
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge clk) #1;
      {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge clk) #1;
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rvalid ? reg_rdata : 24'hXXXXXX;
   endtask
endmodule // acr_host_model

// *** test/acr_regs_chk.sv ***
// assertion checker for the range image, source select and alert flag registers
`timescale 1ns/1ps
module acr_regs_chk #(
   parameter NUM_CH = 4
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [7:0]        reg_addr,
   input wire logic              reg_wr,
   input wire logic [23:0]       reg_wdata,
   input wire logic              reg_rd,
   input wire logic              refresh,
   input wire logic [9:0]        range_active,
   input wire logic              conv_done,
   input wire logic [NUM_CH-1:0] oc_trip,
   input wire logic [23:4]       alert_enable,
   input wire logic [23:0]       reg_rdata,
   input wire logic              reg_rvalid,
   input wire logic [9:0]        range_select_latched_image,
   input wire logic [7:0]        accumulator_source_select,
   input wire logic [23:0]       limit_alert_flags,
   input wire logic [NUM_CH-1:0] accum_src_power,
   input wire logic [NUM_CH-1:0] bus_range_bipolar
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_flag_read: assert property (reg_rd && reg_addr == 8'h26 |=> reg_rvalid && reg_rdata == $past(limit_alert_flags))
      else $error("flag read mismatch");
   a_low_bits_zero: assert property (limit_alert_flags[1:0] == 2'h0)
      else $error("flag bits 1-0 set");
   a_no_reserved_src: assert property (!(|(accumulator_source_select & (accumulator_source_select >> 1) & 8'h55)))
      else $error("reserved source code stored");
   a_src_write: assert property (reg_wr && reg_addr == 8'h25 |=> accumulator_source_select[7:6] ==
      (&$past(reg_wdata[7:6]) ? 2'h0 : $past(reg_wdata[7:6]))) else $error("source write lost");
   a_refresh_latch: assert property (refresh |=> range_select_latched_image == $past(range_active))
      else $error("image not latched");
   a_trip_sets: assert property (conv_done && oc_trip[0] && alert_enable[23] |=> limit_alert_flags[23])
      else $error("enabled trip not flagged");
   a_set_cause: assert property ($rose(limit_alert_flags[23]) |-> $past(conv_done && oc_trip[0] && alert_enable[23]))
      else $error("flag set without cause");
   a_hold_between: assert property (!conv_done |=> $stable(limit_alert_flags))
      else $error("flags moved without conversion");
   a_bus_decode: assert property (1'b1 |=> bus_range_bipolar[0] == ($past(range_select_latched_image[7:6]) == 2'h1 ||
      $past(range_select_latched_image[7:6]) == 2'h2))
      else $error("bus range decode wrong");
   a_src_decode: assert property (1'b1 |=> accum_src_power[0] == ($past(accumulator_source_select[7:6]) == 2'h0))
      else $error("source decode wrong");
endmodule // acr_regs_chk

bind acr_regs acr_regs_chk #(.NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .refresh(refresh), .range_active(range_active),
   .conv_done(conv_done), .oc_trip(oc_trip), .alert_enable(alert_enable), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .range_select_latched_image(range_select_latched_image),
   .accumulator_source_select(accumulator_source_select), .limit_alert_flags(limit_alert_flags),
   .accum_src_power(accum_src_power), .bus_range_bipolar(bus_range_bipolar));

// *** test/acr_regs_test.sv ***
// self-checking testbench for the range image, source select and alert flag registers
`timescale 1ns/1ps
module acr_regs_test;
   logic clk, rst_n, refresh, conv_done, acc_f, cnt_f, a_any, rv, sb, sh, sr;
   logic [7:0] addr, img_src;
   logic [23:0] wdata, rdata, d, flags;
   logic wr, rd;
   logic [9:0] ractive, img;
   logic [3:0] oc, uc, ov, uv, op, s_pw, s_se, s_bu, b_bi, b_ha, b_re;
   logic [23:4] en;
   int fail_count = 0, tests_run = 0;
   acr_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
      .refresh(refresh), .range_active(ractive), .conv_done(conv_done), .oc_trip(oc), .uc_trip(uc), .ov_trip(ov),
      .uv_trip(uv), .op_trip(op), .accum_full_trip(acc_f), .count_full_trip(cnt_f), .alert_enable(en),
      .reg_rdata(rdata), .reg_rvalid(rv), .range_select_latched_image(img), .accumulator_source_select(img_src),
      .limit_alert_flags(flags), .alert_any(a_any), .accum_src_power(s_pw), .accum_src_sense(s_se),
      .accum_src_bus(s_bu), .bus_range_bipolar(b_bi), .bus_range_half(b_ha), .bus_range_reserved(b_re),
      .sense_range_bipolar_ch4(sb), .sense_range_half_ch4(sh), .sense_range_reserved_ch4(sr));
   acr_host_model u_host (.clk(clk), .reg_rvalid(rv), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // one-cycle pulses on refresh and conversion complete
   task automatic step(input logic r, input logic c);
      @(posedge clk) #1;
      {refresh, conv_done} = {r, c};
      @(posedge clk) #1;
      {refresh, conv_done} = 2'b00;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [23:0] exp);
      u_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      fail_count++;
      print_verdict;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_n, refresh, conv_done, acc_f, cnt_f} = 5'b00000;
      {oc, uc, ov, uv, op, en} = {20'h00000, 20'h00000};
      ractive = 10'h1E4;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      rchk(8'h25, 24'h000000);
      chk(s_pw, 4'hF);
      rchk(8'h24, 24'h000000);
      rchk(8'h26, 24'h000000);
      u_host.wr(8'h25, 24'h00001B);
      rchk(8'h25, 24'h000018);
      chk({s_pw, s_se, s_bu}, 12'h924);
      u_host.wr(8'h26, 24'hFFFFFF);
      rchk(8'h27, 24'h000000);
      step(1'b1, 1'b0);
      rchk(8'h24, 24'h0001E4);
      chk({b_re, b_ha, b_bi, sb, sh, sr}, 15'h0934);
      {oc, uc, ov, uv, op, acc_f, en} = {4'h1, 4'h8, 4'h2, 4'h1, 4'h4, 1'b1, 20'hFFFFF};
      step(1'b0, 1'b1);
      chk(flags, 24'h814828);
      chk(a_any, 1'b1);
      {oc, uc, ov, uv, op, acc_f, cnt_f, en} = {21'h000000, 1'b1, 20'h00000};
      step(1'b0, 1'b1);
      rchk(8'h26, 24'h81482C);
      step(1'b0, 1'b1);
      rchk(8'h26, 24'h000004);
      oc = 4'hF;
      step(1'b0, 1'b1);
      chk(flags, 24'h000004);
      print_verdict;
   end
endmodule // acr_regs_test
